// file: cts_pkg.sv
package cts_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_TIME    = 8'h00;
  localparam logic [7:0] OFF_DATE    = 8'h04;
  localparam logic [7:0] OFF_CTRL    = 8'h08;
  localparam logic [7:0] OFF_PRESC   = 8'h0c;
  localparam logic [7:0] OFF_SUBSEC  = 8'h10;
  localparam logic [7:0] OFF_ALARM_A = 8'h14;
  localparam logic [7:0] OFF_ALARM_B = 8'h18;
  localparam logic [7:0] OFF_WKUP    = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;
  localparam logic [7:0] OFF_MASK    = 8'h24;
  localparam logic [7:0] OFF_STORE   = 8'h40;
  localparam int         STORE_WORDS = 20;
  // ctrl fields
  localparam int CTRL_H12    = 0;
  localparam int CTRL_WK_EN  = 1;
  localparam int CTRL_CAL_EN = 2;
  localparam int CTRL_WSEL   = 4;
  localparam int CTRL_LOAD   = 8;
  // status bit positions
  localparam int ST_ALARM_A = 0;
  localparam int ST_ALARM_B = 1;
  localparam int ST_WAKEUP  = 2;
  // prescaler reset: 32768 = 128 * 256
  localparam logic [6:0]  PRESC_A_RST = 7'h7f;
  localparam logic [12:0] PRESC_S_RST = 13'h00ff;
  localparam logic [15:0] WK_RELOAD_RST = 16'hffff;
  // calibration output divides the 32.768 kHz clock by 64
  localparam logic [5:0] CAL_DIV_HALF = 6'h1f;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : cts_pkg

// file: cts_alarm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cts_alarm_if;
  logic [31:0] alarm_word;
  logic [31:0] time_word;
  logic [31:0] date_word;
  logic        tick;
  logic        hit;
  modport ctl (output alarm_word, output time_word, output date_word,
               output tick, input hit);
  modport cmp (input alarm_word, input time_word, input date_word,
               input tick, output hit);
endinterface : cts_alarm_if
`default_nettype wire

// file: cts_alarm_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// alarm word: [6:0] sec [14:8] min [21:16] hour [22] pm [29:24] date
// top bit of each byte masks its own field: 7 sec, 15 min, 23 hour, 31 date
module cts_alarm_cmp
(
  // clock
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // comparison
  cts_alarm_if.cmp  al
);
  logic m_sec;
  logic m_min;
  logic m_hr;
  logic m_dt;
  logic hit_reg;

  always_comb
  begin
    m_sec = al.alarm_word[7] | (al.alarm_word[6:0] == al.time_word[6:0]);
    m_min = al.alarm_word[15] | (al.alarm_word[14:8] == al.time_word[14:8]);
    m_hr  = al.alarm_word[23] |
            (al.alarm_word[22:16] == al.time_word[22:16]);
    m_dt  = al.alarm_word[31] |
            (al.alarm_word[29:24] == al.date_word[5:0]);
  end

  // one pulse on the tick that matches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hit_reg <= 1'b0;
    else if (ce)
      hit_reg <= al.tick & m_sec & m_min & m_hr & m_dt;
  end

  assign al.hit = hit_reg;
endmodule : cts_alarm_cmp
`default_nettype wire

// file: cts_timekeeper.sv
`timescale 1ns/1ps
`default_nettype none
module cts_timekeeper
(
  // system bus clock
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // battery domain reset, only at power-up of the backup supply
  input  wire logic        bat_resetn,
  // 32.768 kHz clock pin
  input  wire logic        lsclk_pin,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // outputs
  output logic             cal_out,
  output logic             wake_req,
  output logic             irq
);
  // lsclk pin synchroniser
  logic [2:0]  ls_sync_reg;
  logic        ls_level_reg;
  logic        ls_rise;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ls_sync_reg  <= 3'h0;
      ls_level_reg <= 1'b0;
    end
    else if (ce)
    begin
      ls_sync_reg <= {ls_sync_reg[1:0], lsclk_pin};
      if (ls_sync_reg[1] == ls_sync_reg[2])
        ls_level_reg <= ls_sync_reg[2];
    end
  end
  assign ls_rise = (ls_sync_reg[1] == ls_sync_reg[2]) & ls_sync_reg[2] &
                   ~ls_level_reg;

  // registers
  logic [31:0] time_reg;
  logic [31:0] date_reg;
  logic [31:0] ctrl_reg;
  logic [6:0]  presc_a_reg;
  logic [12:0] presc_s_reg;
  logic [6:0]  cnt_a_reg;
  logic [12:0] cnt_s_reg;
  logic [31:0] alarm_a_reg;
  logic [31:0] alarm_b_reg;
  logic [15:0] wk_reload_reg;
  logic [15:0] wk_cnt_reg;
  logic        wk_reload_pend_reg;
  logic [2:0]  status_reg;
  logic [2:0]  mask_reg;
  logic [5:0]  cal_div_reg;
  logic        cal_reg;
  logic [15:0] wk_div_reg;

  // axi handshake
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;

  assign s_awready = ~aw_held_reg & ~s_bvalid;
  assign s_wready  = ~w_held_reg & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign wr_fire   = aw_held_reg & w_held_reg & ~s_bvalid;
  assign rd_fire   = s_arvalid & s_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      s_bvalid    <= 1'b0;
      s_bresp     <= cts_pkg::AXI_OKAY;
    end
    else if (ce)
    begin
      if (s_awvalid & s_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_awaddr;
      end
      if (s_wvalid & s_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_wdata;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        s_bvalid    <= 1'b1;
        s_bresp     <= wr_hit ? cts_pkg::AXI_OKAY : cts_pkg::AXI_SLVERR;
      end
      else if (s_bvalid & s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // write enables
  logic we_time;
  logic we_date;
  logic we_ctrl;
  logic we_presc;
  logic we_alm_a;
  logic we_alm_b;
  logic we_wkup;
  logic we_stat;
  logic we_mask;
  logic we_store;
  logic [4:0] st_idx_w;
  logic [7:0] st_off_w;
  always_comb
  begin
    we_time  = wr_fire & (awaddr_reg == cts_pkg::OFF_TIME);
    we_date  = wr_fire & (awaddr_reg == cts_pkg::OFF_DATE);
    we_ctrl  = wr_fire & (awaddr_reg == cts_pkg::OFF_CTRL);
    we_presc = wr_fire & (awaddr_reg == cts_pkg::OFF_PRESC);
    we_alm_a = wr_fire & (awaddr_reg == cts_pkg::OFF_ALARM_A);
    we_alm_b = wr_fire & (awaddr_reg == cts_pkg::OFF_ALARM_B);
    we_wkup  = wr_fire & (awaddr_reg == cts_pkg::OFF_WKUP);
    we_stat  = wr_fire & (awaddr_reg == cts_pkg::OFF_STATUS);
    we_mask  = wr_fire & (awaddr_reg == cts_pkg::OFF_MASK);
    st_off_w = awaddr_reg - cts_pkg::OFF_STORE;
    st_idx_w = st_off_w[6:2];
    we_store = wr_fire & (awaddr_reg >= cts_pkg::OFF_STORE) &
               (st_off_w[7:2] < 6'(cts_pkg::STORE_WORDS)) &
               (awaddr_reg[1:0] == 2'h0);
    wr_hit   = we_time | we_date | we_ctrl | we_presc | we_alm_a |
               we_alm_b | we_wkup | we_stat | we_mask | we_store |
               (wr_fire & (awaddr_reg == cts_pkg::OFF_SUBSEC));
  end

  // prescaler: async stage then sync stage
  logic tick_1s;
  logic ck_spre;
  assign ck_spre = ls_rise & (cnt_a_reg == 7'h00);
  assign tick_1s = ck_spre & (cnt_s_reg == 13'h0000);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      presc_a_reg <= cts_pkg::PRESC_A_RST;
      presc_s_reg <= cts_pkg::PRESC_S_RST;
      cnt_a_reg   <= cts_pkg::PRESC_A_RST;
      cnt_s_reg   <= cts_pkg::PRESC_S_RST;
    end
    else if (ce)
    begin
      if (we_presc)
      begin
        presc_a_reg <= wdata_reg[22:16];
        presc_s_reg <= wdata_reg[12:0];
        cnt_a_reg   <= wdata_reg[22:16];
        cnt_s_reg   <= wdata_reg[12:0];
      end
      else if (ls_rise)
      begin
        cnt_a_reg <= (cnt_a_reg == 7'h00) ? presc_a_reg : cnt_a_reg - 7'h01;
        if (ck_spre)
          cnt_s_reg <= tick_1s ? presc_s_reg : cnt_s_reg - 13'h0001;
      end
    end
  end

  // bcd helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  function automatic logic [7:0] month_len(input logic [7:0] mon,
                                           input logic [7:0] yr);
    logic [7:0] ybin;
    ybin = 8'(yr[7:4] * 4'd10) + 8'(yr[3:0]);
    case (mon)
      8'h02:   month_len = (ybin[1:0] == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction : month_len

  // calendar: time [6:0] sec [14:8] min [21:16] hr [22] pm
  // date [5:0] day [12:8] month [15:13] weekday [23:16] year
  logic [7:0] sec_v;
  logic [7:0] min_v;
  logic [7:0] hr_v;
  logic [7:0] day_v;
  logic [7:0] mon_v;
  logic [7:0] yr_v;
  logic [2:0] wd_v;
  logic       pm_v;
  logic [31:0] time_next;
  logic [31:0] date_next;
  always_comb
  begin
    sec_v = {1'b0, time_reg[6:0]};
    min_v = {1'b0, time_reg[14:8]};
    hr_v  = {2'b0, time_reg[21:16]};
    pm_v  = time_reg[22];
    day_v = {2'b0, date_reg[5:0]};
    mon_v = {3'b0, date_reg[12:8]};
    wd_v  = date_reg[15:13];
    yr_v  = date_reg[23:16];
    if (sec_v == 8'h59)
    begin
      sec_v = 8'h00;
      if (min_v == 8'h59)
      begin
        min_v = 8'h00;
        if (ctrl_reg[cts_pkg::CTRL_H12])
        begin
          if (hr_v == 8'h11)
            pm_v = ~pm_v;
          hr_v = (hr_v == 8'h12) ? 8'h01 : bcd_inc(hr_v);
        end
        else if (hr_v == 8'h23)
          hr_v = 8'h00;
        else
          hr_v = bcd_inc(hr_v);
        if (!ctrl_reg[cts_pkg::CTRL_H12] ? (hr_v == 8'h00) :
            (time_reg[21:16] == 6'h11 && time_reg[22]))
        begin
          wd_v = (wd_v == 3'h7) ? 3'h1 : wd_v + 3'h1;
          if (day_v == month_len(mon_v, yr_v))
          begin
            day_v = 8'h01;
            if (mon_v == 8'h12)
            begin
              mon_v = 8'h01;
              yr_v  = (yr_v == 8'h99) ? 8'h00 : bcd_inc(yr_v);
            end
            else
              mon_v = bcd_inc(mon_v);
          end
          else
            day_v = bcd_inc(day_v);
        end
      end
      else
        min_v = bcd_inc(min_v);
    end
    else
      sec_v = bcd_inc(sec_v);
    time_next = {9'h0, pm_v, hr_v[5:0], 1'b0, min_v[6:0], 1'b0, sec_v[6:0]};
    date_next = {8'h0, yr_v, wd_v, mon_v[4:0], 2'b0, day_v[5:0]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      time_reg <= 32'h0;
      date_reg <= 32'h0000_2101;
    end
    else if (ce)
    begin
      if (we_time)
        time_reg <= wdata_reg & 32'h007f_7f7f;
      else if (tick_1s)
        time_reg <= time_next;
      if (we_date)
        date_reg <= wdata_reg & 32'h00ff_ff3f;
      else if (tick_1s)
        date_reg <= date_next;
    end
  end

  // control and alarm targets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg    <= 32'h0;
      alarm_a_reg <= 32'h0;
      alarm_b_reg <= 32'h0;
      mask_reg    <= 3'h0;
    end
    else if (ce)
    begin
      if (we_ctrl)
        ctrl_reg <= wdata_reg & 32'h0000_0077;
      if (we_alm_a)
        alarm_a_reg <= wdata_reg;
      if (we_alm_b)
        alarm_b_reg <= wdata_reg;
      if (we_mask)
        mask_reg <= wdata_reg[2:0];
    end
  end

  // alarms
  cts_alarm_if alm_a ();
  cts_alarm_if alm_b ();
  // compare what the tick loads, so the flag marks arrival at the target
  assign alm_a.alarm_word = alarm_a_reg;
  assign alm_a.time_word  = time_next;
  assign alm_a.date_word  = date_next;
  assign alm_a.tick       = tick_1s;
  assign alm_b.alarm_word = alarm_b_reg;
  assign alm_b.time_word  = time_next;
  assign alm_b.date_word  = date_next;
  assign alm_b.tick       = tick_1s;
  cts_alarm_cmp u_alm_a (.aclk(aclk), .aresetn(aresetn), .ce(ce),
                         .al(alm_a));
  cts_alarm_cmp u_alm_b (.aclk(aclk), .aresetn(aresetn), .ce(ce),
                         .al(alm_b));

  // wakeup resolution: lsclk/2..lsclk/16 or 1 Hz
  logic wk_tick;
  logic [2:0] wsel;
  assign wsel = ctrl_reg[cts_pkg::CTRL_WSEL +: 3];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wk_div_reg <= 16'h0;
    else if (ce && ls_rise)
      wk_div_reg <= wk_div_reg + 16'h1;
  end
  // 2..16 divide gives ~61..488 us steps (~120 us minimum), 1 Hz gives ~18 h per wrap
  always_comb
  begin
    case (wsel)
      3'h0:    wk_tick = ls_rise & (wk_div_reg[3:0] == 4'hf);
      3'h1:    wk_tick = ls_rise & (wk_div_reg[2:0] == 3'h7);
      3'h2:    wk_tick = ls_rise & (wk_div_reg[1:0] == 2'h3);
      3'h3:    wk_tick = ls_rise & wk_div_reg[0];
      default: wk_tick = tick_1s;
    endcase
  end

  logic wk_zero_evt;
  assign wk_zero_evt = ctrl_reg[cts_pkg::CTRL_WK_EN] & wk_tick &
                       ~wk_reload_pend_reg & (wk_cnt_reg == 16'h0001);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wk_reload_reg      <= cts_pkg::WK_RELOAD_RST;
      wk_cnt_reg         <= cts_pkg::WK_RELOAD_RST;
      wk_reload_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (we_wkup)
      begin
        wk_reload_reg <= wdata_reg[15:0];
        wk_cnt_reg    <= wdata_reg[15:0];
      end
      else if (ctrl_reg[cts_pkg::CTRL_WK_EN] && wk_tick)
      begin
        if (wk_reload_pend_reg || wk_cnt_reg == 16'h0000)
        begin
          wk_cnt_reg         <= wk_reload_reg;
          wk_reload_pend_reg <= 1'b0;
        end
        else
        begin
          wk_cnt_reg <= wk_cnt_reg - 16'h0001;
          if (wk_cnt_reg == 16'h0001)
            wk_reload_pend_reg <= 1'b1;
        end
      end
    end
  end

  // sticky status, set beats write-one clear
  logic [2:0] evt;
  assign evt = {wk_zero_evt, alm_b.hit, alm_a.hit};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= 3'h0;
    else if (ce)
      status_reg <= (status_reg & ~(we_stat ? wdata_reg[2:0] : 3'h0)) |
                    evt;
  end
  assign irq      = |(status_reg & mask_reg);
  assign wake_req = |status_reg;

  // calibration output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cal_div_reg <= 6'h0;
      cal_reg     <= 1'b0;
    end
    else if (ce && ls_rise)
    begin
      if (cal_div_reg == cts_pkg::CAL_DIV_HALF)
      begin
        cal_div_reg <= 6'h0;
        cal_reg     <= ~cal_reg;
      end
      else
        cal_div_reg <= cal_div_reg + 6'h1;
    end
  end
  assign cal_out = cal_reg & ctrl_reg[cts_pkg::CTRL_CAL_EN];

  // backup store on its own reset
  logic [31:0] store_rd;
  logic [4:0]  st_idx_r;
  logic [7:0]  st_off_r;
  logic [4:0]  rd_idx_reg;
  logic [4:0]  st_raddr;
  assign st_off_r = s_araddr - cts_pkg::OFF_STORE;
  assign st_idx_r = st_off_r[6:2];
  // hold the taken index so the word stays put while rvalid waits
  assign st_raddr = rd_fire ? st_idx_r : rd_idx_reg;
  cts_store_mem #(.WORDS(cts_pkg::STORE_WORDS)) u_store (
    .aclk       (aclk),
    .bat_resetn (bat_resetn),
    .ce         (ce),
    .we         (we_store),
    .waddr      (st_idx_w),
    .wdata      (wdata_reg),
    .raddr      (st_raddr),
    .rdata      (store_rd)
  );

  // read path
  logic        rd_store_reg;
  logic [31:0] rdata_reg;
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    case (s_araddr)
      cts_pkg::OFF_TIME:    rd_word = time_reg;
      cts_pkg::OFF_DATE:    rd_word = date_reg;
      cts_pkg::OFF_CTRL:    rd_word = ctrl_reg;
      cts_pkg::OFF_PRESC:   rd_word = {9'h0, presc_a_reg, 3'h0, presc_s_reg};
      cts_pkg::OFF_SUBSEC:  rd_word = {19'h0, cnt_s_reg};
      cts_pkg::OFF_ALARM_A: rd_word = alarm_a_reg;
      cts_pkg::OFF_ALARM_B: rd_word = alarm_b_reg;
      cts_pkg::OFF_WKUP:    rd_word = {wk_cnt_reg, wk_reload_reg};
      cts_pkg::OFF_STATUS:  rd_word = {29'h0, status_reg};
      cts_pkg::OFF_MASK:    rd_word = {29'h0, mask_reg};
      default:
        rd_hit = (s_araddr >= cts_pkg::OFF_STORE) &&
                 (st_off_r[7:2] < 6'(cts_pkg::STORE_WORDS)) &&
                 (s_araddr[1:0] == 2'h0);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid     <= 1'b0;
      s_rresp      <= cts_pkg::AXI_OKAY;
      rdata_reg    <= 32'h0;
      rd_store_reg <= 1'b0;
      rd_idx_reg   <= 5'h0;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        s_rvalid     <= 1'b1;
        s_rresp      <= rd_hit ? cts_pkg::AXI_OKAY : cts_pkg::AXI_SLVERR;
        rdata_reg    <= rd_word;
        rd_store_reg <= (s_araddr >= cts_pkg::OFF_STORE) & rd_hit;
        rd_idx_reg   <= st_idx_r;
      end
      else if (s_rvalid & s_rready)
        s_rvalid <= 1'b0;
    end
  end
  // store word comes straight from the memory's own output register
  assign s_rdata = rd_store_reg ? store_rd : rdata_reg;
endmodule : cts_timekeeper
`default_nettype wire

// file: cts_store_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cts_store_mem #(
  parameter int WORDS = 20
)
(
  // clock and battery reset
  input  wire logic        aclk,
  input  wire logic        bat_resetn,
  input  wire logic        ce,
  // write
  input  wire logic        we,
  input  wire logic [4:0]  waddr,
  input  wire logic [31:0] wdata,
  // read
  input  wire logic [4:0]  raddr,
  output logic [31:0]      rdata
);
  if (WORDS < 1 || WORDS > 32)
  begin : g_bad_words
    $error("store depth out of range");
  end
  logic [31:0] mem_reg [WORDS];
  // only the battery reset clears it; system reset never reaches here
  always_ff @(posedge aclk)
  begin
    if (!bat_resetn)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_reg[i] <= 32'h0;
    end
    else if (ce && we && int'(waddr) < WORDS)
      mem_reg[waddr] <= wdata;
  end
  always_ff @(posedge aclk)
  begin
    if (!bat_resetn)
      rdata <= 32'h0;
    else if (ce)
      rdata <= (int'(raddr) < WORDS) ? mem_reg[raddr] : 32'h0;
  end
endmodule : cts_store_mem
`default_nettype wire

// file: cts_timekeeper_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cts_tk_chk
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  // bus handshakes
  input wire logic       s_arvalid,
  input wire logic       s_arready,
  input wire logic       s_bvalid,
  input wire logic       s_bready,
  input wire logic       s_rvalid,
  input wire logic       s_rready,
  input wire logic [1:0] s_rresp,
  // outputs
  input wire logic       cal_out,
  input wire logic       wake_req,
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_rvalid && !s_rready |=> s_rvalid;
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_rlat;
    s_arvalid && s_arready && ce |=> s_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rresp;
    s_rvalid |-> s_rresp == cts_pkg::AXI_OKAY ||
                 s_rresp == cts_pkg::AXI_SLVERR;
  endproperty
  a_rresp: assert property (p_rresp) else $error("bad read resp");
  property p_irq;
    irq |-> wake_req;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without event");
  property p_wfall;
    $fell(wake_req) |-> ##[0:1] s_bvalid;
  endproperty
  a_wfall: assert property (p_wfall) else $error("flag lost");
  property p_ifall;
    $fell(irq) |-> ##[0:1] s_bvalid;
  endproperty
  a_ifall: assert property (p_ifall) else $error("irq lost");
  property p_cal;
    $fell(cal_out) |=> (!cal_out) [*8];
  endproperty
  a_cal: assert property (p_cal) else $error("cal too fast");
  property p_rst;
    disable iff (1'b0) !aresetn |=> !s_bvalid && !s_rvalid && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not clean");
endmodule : cts_tk_chk
bind cts_timekeeper cts_tk_chk u_chk
(
  .aclk      (aclk),
  .aresetn   (aresetn),
  .ce        (ce),
  .s_arvalid (s_arvalid),
  .s_arready (s_arready),
  .s_bvalid  (s_bvalid),
  .s_bready  (s_bready),
  .s_rvalid  (s_rvalid),
  .s_rready  (s_rready),
  .s_rresp   (s_rresp),
  .cal_out   (cal_out),
  .wake_req  (wake_req),
  .irq       (irq)
);
`default_nettype wire

// file: cts_timekeeper_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cts_timekeeper_bench;
  // pin clock far above 32.768 kHz to keep the run short
  localparam int LS_HALF = 10;
  logic        aclk, aresetn, bat_resetn, lsclk_pin, cal_out, wake_req, irq;
  logic [7:0]  s_awaddr, s_araddr, a;
  logic [31:0] s_wdata, s_rdata, v;
  logic [31:0] mem [20];
  logic [3:0]  s_wstrb;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, lv;
  logic [1:0]  s_bresp, s_rresp, r;
  int          err_total, checked;
  time         t0;
  cts_timekeeper uut
  (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bat_resetn(bat_resetn),
    .lsclk_pin(lsclk_pin), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .cal_out(cal_out), .wake_req(wake_req), .irq(irq)
  );
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    lsclk_pin = 1'b0;
    forever #(LS_HALF * 10) lsclk_pin = ~lsclk_pin;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge aclk);
    s_awaddr  <= ad;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (b)
    begin
      @(negedge aclk);
      r = s_bresp;
      if (s_bvalid === 1'b1) b = 1'b0;
      if (s_awready === 1'b1) aw = 1'b0;
      if (s_wready === 1'b1) w = 1'b0;
      @(posedge aclk);
      s_awvalid <= aw;
      s_wvalid  <= w;
      s_bready  <= b;
    end
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    logic ar, b;
    ar = 1'b1;
    b = 1'b1;
    @(posedge aclk);
    s_araddr  <= ad;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    while (b)
    begin
      @(negedge aclk);
      v = s_rdata;
      r = s_rresp;
      if (s_rvalid === 1'b1) b = 1'b0;
      if (s_arready === 1'b1) ar = 1'b0;
      @(posedge aclk);
      s_arvalid <= ar;
      s_rready  <= b;
    end
  endtask : rd
  task automatic wait_wake;
    while (wake_req !== 1'b1) @(negedge aclk);
  endtask : wait_wake
  task automatic wait_cal;
    lv = cal_out;
    while (cal_out === lv) @(negedge aclk);
  endtask : wait_cal
  function automatic logic [1:0] exp_resp(input logic [7:0] ad);
    if (ad[1:0] == 2'h0 && (ad <= cts_pkg::OFF_MASK ||
        (ad >= cts_pkg::OFF_STORE && ad <= 8'h8c)))
      return cts_pkg::AXI_OKAY;
    return cts_pkg::AXI_SLVERR;
  endfunction : exp_resp
  function automatic logic [31:0] bcd_ok(input logic [31:0] t);
    return {31'h0, t[3:0] <= 4'h9 && t[6:4] <= 3'h5 && t[11:8] <= 4'h9
            && t[14:12] <= 3'h5};
  endfunction : bcd_ok
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (60000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
  initial
  begin
    err_total = 0;
    checked = 0;
    {aresetn, bat_resetn, s_awvalid, s_wvalid, s_bready} = 5'h0;
    {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = 50'h0;
    s_wstrb = 4'hf;
    v = $urandom(12908);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bat_resetn <= 1'b1;
    rd(cts_pkg::OFF_PRESC);
    chk(v, 32'h007f00ff);
    rd(cts_pkg::OFF_DATE);
    chk(v, 32'h00002101);
    rd(cts_pkg::OFF_WKUP);
    chk({16'h0, v[15:0]}, 32'h0000ffff);
    wr(8'h30, 32'h1);
    chk({30'h0, r}, {30'h0, cts_pkg::AXI_SLVERR});
    for (int i = 0; i < 24; i++)
    begin
      a = (i == 0) ? 8'h02 : 8'($urandom_range(0, 159));
      rd(a);
      chk({30'h0, r}, {30'h0, exp_resp(a)});
    end
    $display("done map");
    for (int i = 0; i < 20; i++)
    begin
      mem[i] = $urandom();
      wr(cts_pkg::OFF_STORE + 8'(4 * i), mem[i]);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      rd(cts_pkg::OFF_STORE + 8'(4 * i));
      chk(v, mem[i]);
    end
    $display("done store");
    // one second is two rising pin edges from here on
    wr(cts_pkg::OFF_PRESC, 32'h00000001);
    wr(cts_pkg::OFF_ALARM_A, 32'h80808003);
    wr(cts_pkg::OFF_ALARM_B, 32'h31235959);
    wr(cts_pkg::OFF_STATUS, 32'h7);
    wait_wake();
    chk({31'h0, irq}, 32'h0);
    rd(cts_pkg::OFF_TIME);
    chk({25'h0, v[6:0]}, 32'h3);
    wr(cts_pkg::OFF_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    repeat (100) @(posedge aclk);
    wr(cts_pkg::OFF_STATUS, 32'h2);
    rd(cts_pkg::OFF_STATUS);
    chk(v, 32'h1);
    wr(cts_pkg::OFF_STATUS, 32'h1);
    chk({30'h0, irq, wake_req}, 32'h0);
    repeat (20)
    begin
      repeat ($urandom_range(1, 60)) @(posedge aclk);
      rd(cts_pkg::OFF_TIME);
      chk(bcd_ok(v), 32'h1);
    end
    wr(cts_pkg::OFF_ALARM_A, 32'h0);
    wr(cts_pkg::OFF_DATE, 32'h0000_2228);
    wr(cts_pkg::OFF_TIME, 32'h0023_5959);
    repeat (50) @(posedge aclk);
    rd(cts_pkg::OFF_DATE);
    chk(v, 32'h0000_4229);
    $display("done alarm");
    wr(cts_pkg::OFF_MASK, 32'h4);
    wr(cts_pkg::OFF_WKUP, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      wr(cts_pkg::OFF_CTRL, 32'(k << 4) | 32'h2);
      wr(cts_pkg::OFF_STATUS, 32'h7);
      wait_wake();
      t0 = $time;
      chk({31'h0, irq}, 32'h1);
      wr(cts_pkg::OFF_STATUS, 32'h4);
      wait_wake();
      chk(32'(($time - t0) / 10), 32'(2 * (16 >> k) * 2 * LS_HALF));
    end
    wr(cts_pkg::OFF_CTRL, 32'h4);
    wr(cts_pkg::OFF_STATUS, 32'h4);
    $display("done wakeup");
    wait_cal();
    wait_cal();
    t0 = $time;
    wait_cal();
    chk(32'(($time - t0) / 10), 32'(64 * LS_HALF));
    wr(cts_pkg::OFF_CTRL, 32'h0);
    rd(cts_pkg::OFF_CTRL);
    chk({31'h0, cal_out}, 32'h0);
    $display("done cal");
    end_of_test();
  end
endmodule : cts_timekeeper_bench
`default_nettype wire
